// File: iosad_decoder.v
`timescale 1ns/10ps

module iosad_decoder (
    // Clock and reset
    input  wire       i_clk_sys,
    input  wire       i_resetn,
    // Core request
    input  wire       i_req_valid,         // Request taken on this edge
    input  wire [2:0] i_req_op,            // Operation code
    input  wire [7:0] i_req_addr,          // I/O address or data address
    input  wire [2:0] i_req_bit,           // Bit select for bit operations
    input  wire [7:0] i_req_wdata,         // Write data for OUT and store
    // Core answer
    output reg        o_rsp_valid,         // One-cycle answer strobe
    output reg  [7:0] o_rsp_rdata,         // Read data
    output reg        o_rsp_skip,          // Skip the next instruction
    output reg        o_rsp_err,           // Address illegal for the operation
    // Peripheral side
    output reg        o_per_sel,           // Access to any legal data-space location, own registers included
    output reg        o_per_wr,            // Write strobe
    output reg  [7:0] o_per_addr,          // Data-space address
    output reg  [7:0] o_per_wmask,         // Bits the write may change
    output reg  [7:0] o_per_wdata,         // Write data
    input  wire       i_per_hit,           // Peripheral owns the address
    input  wire [7:0] i_per_rdata,         // Peripheral read data
    // Status flag events
    input  wire [7:0] i_flag_event,        // Per-bit set pulses
    output wire [7:0] o_flags              // Current flag byte
);
    `include "iosad_regs.vh"

    // ============================================================
    // Request decode (stage 0)
    // ============================================================
    reg       dec_legal;                   // Address allowed for the operation
    reg [7:0] dec_ds_addr;                 // Address in data space
    reg       dec_wr;                      // Operation writes
    reg [7:0] dec_wmask;                   // Write mask
    reg [7:0] dec_wdata;                   // Write data after bit expansion
    reg [7:0] bit_onehot;                  // Selected bit as a mask

    always @* begin
        bit_onehot  = 8'h01 << i_req_bit;
        dec_legal   = 1'b0;
        dec_ds_addr = 8'h00;
        dec_wr      = 1'b0;
        dec_wmask   = 8'hFF;
        dec_wdata   = i_req_wdata;
        case (i_req_op)
            `IOSAD_OP_IN, `IOSAD_OP_OUT: begin
                // Six-bit address field, no extended region
                dec_legal   = (i_req_addr <= `IOSAD_IO_LAST);
                dec_ds_addr = i_req_addr + `IOSAD_IO_DS_OFFSET;
                dec_wr      = (i_req_op == `IOSAD_OP_OUT);
            end
            `IOSAD_OP_SET_BIT, `IOSAD_OP_CLR_BIT: begin
                // Only the low region is bit addressable
                dec_legal   = (i_req_addr <= `IOSAD_BIT_LAST);
                dec_ds_addr = i_req_addr + `IOSAD_IO_DS_OFFSET;
                dec_wr      = 1'b1;
                dec_wmask   = bit_onehot;
                dec_wdata   = (i_req_op == `IOSAD_OP_SET_BIT) ? 8'hFF : 8'h00;
            end
            `IOSAD_OP_SKIP_SET, `IOSAD_OP_SKIP_CLR: begin
                // Bit test uses the same low region
                dec_legal   = (i_req_addr <= `IOSAD_BIT_LAST);
                dec_ds_addr = i_req_addr + `IOSAD_IO_DS_OFFSET;
            end
            `IOSAD_OP_LOAD, `IOSAD_OP_STORE: begin
                // Data-space form reaches the whole I/O and extended space
                dec_legal   = (i_req_addr >= `IOSAD_IO_DS_OFFSET);
                dec_ds_addr = i_req_addr;
                dec_wr      = (i_req_op == `IOSAD_OP_STORE);
            end
            default: begin
                dec_legal = 1'b0;
            end
        endcase
    end

    // ============================================================
    // Stage 1 holding flops
    // ============================================================
    reg       s1_valid;                    // A request sits in stage 1
    reg       s1_legal;                    // Its address was legal
    reg [2:0] s1_op;                       // Its operation
    reg [2:0] s1_bit;                      // Its bit select

    // Register the decoded request; the peripheral sees flopped signals
    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            s1_valid    <= 1'b0;
            s1_legal    <= 1'b0;
            s1_op       <= `IOSAD_OP_IN;
            s1_bit      <= 3'h0;
            o_per_sel   <= 1'b0;
            o_per_wr    <= 1'b0;
            o_per_addr  <= 8'h00;
            o_per_wmask <= 8'h00;
            o_per_wdata <= 8'h00;
        end else begin
            s1_valid    <= i_req_valid;
            s1_legal    <= dec_legal;
            s1_op       <= i_req_op;
            s1_bit      <= i_req_bit;
            // Illegal requests never reach any location
            o_per_sel   <= i_req_valid & dec_legal;
            o_per_wr    <= i_req_valid & dec_legal & dec_wr;
            o_per_addr  <= dec_ds_addr;
            o_per_wmask <= dec_wmask;
            o_per_wdata <= dec_wdata;
        end
    end

    // ============================================================
    // Internal registers
    // ============================================================
    wire [7:0] ds_stat = `IOSAD_STAT_IO + `IOSAD_IO_DS_OFFSET; // Flag byte address
    wire [7:0] ds_gs0  = `IOSAD_GS0_IO + `IOSAD_IO_DS_OFFSET;  // Storage 0 address
    wire [7:0] ds_gs1  = `IOSAD_GS1_IO + `IOSAD_IO_DS_OFFSET;  // Storage 1 address
    wire [7:0] ds_gs2  = `IOSAD_GS2_IO + `IOSAD_IO_DS_OFFSET;  // Storage 2 address

    wire       hit_stat = (o_per_addr == ds_stat);             // Flag byte selected
    wire       hit_gs0  = (o_per_addr == ds_gs0);              // Storage 0 selected
    wire       hit_gs1  = (o_per_addr == ds_gs1);              // Storage 1 selected
    wire       hit_gs2  = (o_per_addr == ds_gs2);              // Storage 2 selected

    wire [7:0] val_gs0;                    // Storage 0 contents
    wire [7:0] val_gs1;                    // Storage 1 contents
    wire [7:0] val_gs2;                    // Storage 2 contents

    // Status flags: hardware sets, software clears by writing ones
    iosad_byte_reg #(.CLEAR_ON_ONE(1)) u_flags (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_wr      (o_per_wr & hit_stat),
        .i_wmask   (o_per_wmask),
        .i_wdata   (o_per_wdata),
        .i_set     (i_flag_event),
        .o_value   (o_flags)
    );

    // General storage, no side effects on read or write
    iosad_byte_reg #(.CLEAR_ON_ONE(0)) u_general_store_reg_0 (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_wr      (o_per_wr & hit_gs0),
        .i_wmask   (o_per_wmask),
        .i_wdata   (o_per_wdata),
        .i_set     (8'h00),
        .o_value   (val_gs0)
    );

    iosad_byte_reg #(.CLEAR_ON_ONE(0)) u_general_store_reg_1 (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_wr      (o_per_wr & hit_gs1),
        .i_wmask   (o_per_wmask),
        .i_wdata   (o_per_wdata),
        .i_set     (8'h00),
        .o_value   (val_gs1)
    );

    iosad_byte_reg #(.CLEAR_ON_ONE(0)) u_general_store_reg_2 (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_wr      (o_per_wr & hit_gs2),
        .i_wmask   (o_per_wmask),
        .i_wdata   (o_per_wdata),
        .i_set     (8'h00),
        .o_value   (val_gs2)
    );

    // ============================================================
    // Read return and skip decision
    // ============================================================
    reg [7:0] rd_value;                    // Byte read at the stage-1 address
    reg       bit_value;                   // Selected bit of that byte

    // Own registers first; unclaimed addresses read zero
    always @* begin
        if (!s1_legal) begin
            rd_value = 8'h00;
        end else if (hit_stat) begin
            rd_value = o_flags;
        end else if (hit_gs0) begin
            rd_value = val_gs0;
        end else if (hit_gs1) begin
            rd_value = val_gs1;
        end else if (hit_gs2) begin
            rd_value = val_gs2;
        end else if (i_per_hit) begin
            rd_value = i_per_rdata;
        end else begin
            rd_value = 8'h00;
        end
        bit_value = rd_value[s1_bit];
    end

    // Answer flops, one cycle after stage 1
    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= 8'h00;
            o_rsp_skip  <= 1'b0;
            o_rsp_err   <= 1'b0;
        end else begin
            o_rsp_valid <= s1_valid;
            o_rsp_err   <= s1_valid & ~s1_legal;
            // Byte reads return data; writes and bit tests answer with zero
            if ((s1_op == `IOSAD_OP_IN) || (s1_op == `IOSAD_OP_LOAD)) begin
                o_rsp_rdata <= rd_value;
            end else begin
                o_rsp_rdata <= 8'h00;
            end
            // Skip when the tested bit matches the wanted level
            case (s1_op)
                `IOSAD_OP_SKIP_SET: o_rsp_skip <= s1_valid & s1_legal & bit_value;
                `IOSAD_OP_SKIP_CLR: o_rsp_skip <= s1_valid & s1_legal & ~bit_value;
                default:            o_rsp_skip <= 1'b0;
            endcase
        end
    end

    // Writes to unclaimed addresses go out with o_per_wr but nothing here
    // stores them; a peripheral that does not claim the address must drop it.
endmodule // iosad_decoder

// File: iosad_regs.vh
`ifndef IOSAD_REGS_VH
`define IOSAD_REGS_VH

// ============================================================
// Address map: I/O addresses, plus the data-space offset and the extended region in data-space bytes
// ============================================================
`define IOSAD_IO_DS_OFFSET  8'h20
`define IOSAD_IO_LAST       8'h3F
`define IOSAD_BIT_LAST      8'h1F
`define IOSAD_EXT_FIRST     8'h60
`define IOSAD_EXT_LAST      8'hFF
`define IOSAD_STAT_IO       8'h1B
`define IOSAD_GS0_IO        8'h1C
`define IOSAD_GS1_IO        8'h1D
`define IOSAD_GS2_IO        8'h1E

// ============================================================
// Reset values
// ============================================================
`define IOSAD_STAT_RESET    8'h00
`define IOSAD_GS_RESET      8'h00

// ============================================================
// Request operation codes
// ============================================================
`define IOSAD_OP_IN         3'h0
`define IOSAD_OP_OUT        3'h1
`define IOSAD_OP_SET_BIT    3'h2
`define IOSAD_OP_CLR_BIT    3'h3
`define IOSAD_OP_SKIP_SET   3'h4
`define IOSAD_OP_SKIP_CLR   3'h5
`define IOSAD_OP_LOAD       3'h6
`define IOSAD_OP_STORE      3'h7

`endif

// File: iosad_byte_reg.v
`timescale 1ns/10ps

// ============================================================
// One byte of I/O storage with masked writes
// ============================================================
module iosad_byte_reg #(
    parameter CLEAR_ON_ONE = 0             // 1: bits are write-one-to-clear flags
) (
    // Clock and reset
    input  wire       i_clk_sys,
    input  wire       i_resetn,
    // Write port
    input  wire       i_wr,                // Write strobe
    input  wire [7:0] i_wmask,             // Bits the write may touch
    input  wire [7:0] i_wdata,             // Write data
    // Hardware events
    input  wire [7:0] i_set,               // Per-bit set events
    // State
    output reg  [7:0] o_value              // Stored byte
);
    `include "iosad_regs.vh"

    reg [7:0] next_value;                  // Value for the next edge

    // Next value: masked write, then hardware sets on top
    always @* begin
        next_value = o_value;
        if (i_wr) begin
            if (CLEAR_ON_ONE != 0) begin
                // Only ones inside the mask clear; zeros leave bits alone
                next_value = o_value & ~(i_wmask & i_wdata);
            end else begin
                // Plain storage, untouched bits keep their value
                next_value = (o_value & ~i_wmask) | (i_wdata & i_wmask);
            end
        end
        // A set in the clearing cycle wins so no event is lost
        next_value = next_value | i_set;
    end

    // Storage flop
    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            // Flag bytes and storage bytes each take their own reset value
            o_value <= (CLEAR_ON_ONE != 0) ? `IOSAD_STAT_RESET : `IOSAD_GS_RESET;
        end else begin
            o_value <= next_value;
        end
    end
endmodule // iosad_byte_reg

// File: iosad_decoder_props.sv
`timescale 1ns/10ps
`include "iosad_regs.vh"

// ============================================================
// Port checker for the I/O space decoder
// ============================================================
module iosad_decoder_props (
    // Clock and reset
    input wire       i_clk_sys,
    input wire       i_resetn,
    // Core side
    input wire       i_req_valid,
    input wire [2:0] i_req_op,
    input wire [7:0] i_req_addr,
    input wire [2:0] i_req_bit,
    input wire       o_rsp_valid,
    input wire [7:0] o_rsp_rdata,
    input wire       o_rsp_err,
    // Peripheral side
    input wire       o_per_sel,
    input wire       o_per_wr,
    input wire [7:0] o_per_addr,
    input wire [7:0] o_per_wmask,
    input wire [7:0] o_per_wdata,
    input wire       i_per_hit,
    input wire [7:0] i_per_rdata,
    // Flags
    input wire [7:0] i_flag_event,
    input wire [7:0] o_flags
);
    // Bits a write to the flag byte clears this cycle
    wire [7:0] flag_clr = (o_per_sel && o_per_wr && o_per_addr == 8'h3B) ?
                          (o_per_wdata & o_per_wmask) : 8'h00;
    // Request classes; bit ops have the narrower legal range
    wire       io_op    = i_req_valid && (i_req_op <= `IOSAD_OP_SKIP_CLR);
    wire       bit_op   = io_op && (i_req_op >= `IOSAD_OP_SET_BIT);
    wire       ds_op    = i_req_valid && (i_req_op >= `IOSAD_OP_LOAD);
    wire [7:0] io_top   = bit_op ? 8'h1F : 8'h3F;
    // Own locations answer internally, so peripheral data is ignored there
    wire       foreign  = (o_per_addr < 8'h3B) || (o_per_addr > 8'h3E);

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    AST_RSP_LAT: assert property (i_req_valid |-> ##2 o_rsp_valid)
        else $error("answer not two cycles after request");
    AST_RSP_CAUSE: assert property (o_rsp_valid |-> $past(i_req_valid, 2))
        else $error("answer without request");
    AST_IO_MAP: assert property (io_op && i_req_addr <= io_top |=>
        o_per_sel && o_per_addr == $past(i_req_addr) + 8'h20)
        else $error("I/O address not mapped with offset");
    AST_IO_REFUSE: assert property (io_op && i_req_addr > io_top |=>
        !o_per_sel ##1 o_rsp_err && o_rsp_rdata == 8'h00)
        else $error("out of range I/O access not refused");
    AST_BIT_MASK: assert property (bit_op && i_req_op <= `IOSAD_OP_CLR_BIT &&
        i_req_addr <= 8'h1F |=> o_per_wr && o_per_wmask == (8'h01 << $past(i_req_bit)))
        else $error("bit operation mask not one-hot");
    AST_DS_MAP: assert property (ds_op && i_req_addr >= 8'h20 |=> o_per_sel &&
        o_per_addr == $past(i_req_addr) && o_per_wr == $past(i_req_op[0]))
        else $error("data-space access not passed through");
    AST_FLAG_UPD: assert property (1'b1 |=>
        o_flags == (($past(o_flags) & ~$past(flag_clr)) | $past(i_flag_event)))
        else $error("flag byte update wrong");
    AST_UNMAPPED: assert property (o_per_sel && !o_per_wr && !i_per_hit && foreign
        |=> o_rsp_rdata == 8'h00)
        else $error("unclaimed read not zero");
    // Only byte reads return data; bit tests answer with zero data
    AST_PER_READ: assert property (o_per_sel && !o_per_wr && i_per_hit && foreign &&
        ($past(i_req_op) == `IOSAD_OP_IN || $past(i_req_op) == `IOSAD_OP_LOAD)
        |=> o_rsp_rdata == $past(i_per_rdata))
        else $error("peripheral read data lost");
endmodule // iosad_decoder_props

bind iosad_decoder iosad_decoder_props i_props (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
    .i_req_op(i_req_op), .i_req_addr(i_req_addr), .i_req_bit(i_req_bit),
    .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .o_rsp_err(o_rsp_err),
    .o_per_sel(o_per_sel), .o_per_wr(o_per_wr), .o_per_addr(o_per_addr),
    .o_per_wmask(o_per_wmask), .o_per_wdata(o_per_wdata), .i_per_hit(i_per_hit),
    .i_per_rdata(i_per_rdata), .i_flag_event(i_flag_event), .o_flags(o_flags));

// File: iosad_per_model.sv
`timescale 1ns/10ps

// ============================================================
// Peripheral model: bytes at data 0x40 and extended 0xC0
// ============================================================
module iosad_per_model (
    // Decoder peripheral port
    input  wire       i_clk_sys,
    input  wire       i_sel,
    input  wire       i_wr,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wmask,
    input  wire [7:0] i_wdata,
    output wire       o_hit,
    output wire [7:0] o_rdata
);
    reg [7:0] mem [0:1];    // Indexed by address bit 7

    // Claim only the two owned bytes
    assign o_hit = (i_addr == 8'h40) || (i_addr == 8'hC0);
    // Unclaimed reads show a varying pattern, so a forwarded value gets noticed
    assign o_rdata = o_hit ? mem[i_addr[7]] : ~i_addr;

    // Only masked bits change
    always @(posedge i_clk_sys) begin
        if (i_sel && i_wr && o_hit) begin
            mem[i_addr[7]] <= (mem[i_addr[7]] & ~i_wmask) | (i_wdata & i_wmask);
        end
    end
endmodule // iosad_per_model

// File: io_space_access_decoder_tb.sv
`timescale 1ns/10ps
`include "iosad_regs.vh"

// ============================================================
// Self-checking bench for the I/O space decoder
// ============================================================
module io_space_access_decoder_tb;
    reg        clk = 1'b0;
    reg        resetn = 1'b0;
    reg        req_valid = 1'b0;
    reg  [2:0] req_op = 3'h0, req_bit = 3'h0;
    reg  [7:0] req_addr = 8'h00, req_wdata = 8'h00, flag_event = 8'h00;
    wire       rsp_valid, rsp_skip, rsp_err, per_sel, per_wr, per_hit;
    wire [7:0] rsp_rdata, per_addr, per_wmask, per_wdata, per_rdata, flags;
    integer    errors = 0, check_count = 0, i;

    always #2 clk = ~clk;

    iosad_decoder i_dut (.i_clk_sys(clk), .i_resetn(resetn), .i_req_valid(req_valid),
        .i_req_op(req_op), .i_req_addr(req_addr), .i_req_bit(req_bit),
        .i_req_wdata(req_wdata), .o_rsp_valid(rsp_valid), .o_rsp_rdata(rsp_rdata),
        .o_rsp_skip(rsp_skip), .o_rsp_err(rsp_err), .o_per_sel(per_sel), .o_per_wr(per_wr),
        .o_per_addr(per_addr), .o_per_wmask(per_wmask), .o_per_wdata(per_wdata),
        .i_per_hit(per_hit), .i_per_rdata(per_rdata), .i_flag_event(flag_event),
        .o_flags(flags));
    iosad_per_model i_per (.i_clk_sys(clk), .i_sel(per_sel), .i_wr(per_wr),
        .i_addr(per_addr), .i_wmask(per_wmask), .i_wdata(per_wdata), .o_hit(per_hit),
        .o_rdata(per_rdata));

    task close_out;
        begin
            $display("checks %0d mismatches %0d", check_count, errors);
            if (errors == 0 && check_count > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask

    task chk(input [7:0] got, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // One request, then judge data, skip and error against expectations
    task xfer(input [2:0] op, input [7:0] a, input [2:0] b, input [7:0] wd,
              input [7:0] erd, input esk, input eer);
        integer n;
        begin
            @(posedge clk);
            req_valid <= 1'b1;
            req_op    <= op;
            req_addr  <= a;
            req_bit   <= b;
            req_wdata <= wd;
            @(posedge clk);
            req_valid <= 1'b0;
            n = 0;
            // The answer stands one cycle; bounded wait for it
            do begin
                @(posedge clk);
                #1 n = n + 1;
            end while (rsp_valid !== 1'b1 && n < 4);
            if (rsp_valid !== 1'b1) begin
                errors = errors + 1;
                $display("MISMATCH t=%0t no answer", $time);
                close_out;
            end else begin
                chk(rsp_rdata, erd);
                chk({7'h00, rsp_skip}, {7'h00, esk});
                chk({7'h00, rsp_err}, {7'h00, eer});
            end
        end
    endtask

    // General storage through both I/O and data-space forms
    task t_store;
        for (i = 0; i < 3; i = i + 1) begin
            xfer(`IOSAD_OP_OUT, 8'h1C + i, 3'h0, 8'h5A + i, 8'h00, 1'h0, 1'h0);
            xfer(`IOSAD_OP_LOAD, 8'h3C + i, 3'h0, 8'h00, 8'h5A + i, 1'h0, 1'h0);
            xfer(`IOSAD_OP_STORE, 8'h3C + i, 3'h0, 8'hA0 + i, 8'h00, 1'h0, 1'h0);
            xfer(`IOSAD_OP_IN, 8'h1C + i, 3'h0, 8'h00, 8'hA0 + i, 1'h0, 1'h0);
        end
        $display("test store done");
    endtask

    // Peripheral and extended region, plus refused forms
    task t_periph;
        xfer(`IOSAD_OP_OUT, 8'h20, 3'h0, 8'h33, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_LOAD, 8'h40, 3'h0, 8'h00, 8'h33, 1'h0, 1'h0);
        xfer(`IOSAD_OP_STORE, 8'hC0, 3'h0, 8'h77, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_IN, 8'hA0, 3'h0, 8'h00, 8'h00, 1'h0, 1'h1);
        xfer(`IOSAD_OP_OUT, 8'hC0, 3'h0, 8'h11, 8'h00, 1'h0, 1'h1);
        xfer(`IOSAD_OP_SET_BIT, 8'h20, 3'h1, 8'h00, 8'h00, 1'h0, 1'h1);
        xfer(`IOSAD_OP_SKIP_SET, 8'h20, 3'h1, 8'h00, 8'h00, 1'h0, 1'h1);
        xfer(`IOSAD_OP_LOAD, 8'hC0, 3'h0, 8'h00, 8'h77, 1'h0, 1'h0);
        $display("test periph done");
    endtask

    // Single-bit set, clear and skip tests on storage 1
    task t_bits;
        xfer(`IOSAD_OP_OUT, 8'h1D, 3'h0, 8'h0F, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_SET_BIT, 8'h1D, 3'h7, 8'h00, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_CLR_BIT, 8'h1D, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_IN, 8'h1D, 3'h0, 8'h00, 8'h8E, 1'h0, 1'h0);
        xfer(`IOSAD_OP_SKIP_SET, 8'h1D, 3'h7, 8'h00, 8'h00, 1'h1, 1'h0);
        xfer(`IOSAD_OP_SKIP_CLR, 8'h1D, 3'h7, 8'h00, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_SKIP_CLR, 8'h1D, 3'h0, 8'h00, 8'h00, 1'h1, 1'h0);
        xfer(`IOSAD_OP_SKIP_SET, 8'h1D, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        $display("test bits done");
    endtask

    // Flags: set by events, cleared only by written ones
    task t_flags;
        @(posedge clk);
        flag_event <= 8'h0F;
        @(posedge clk);
        flag_event <= 8'h00;
        xfer(`IOSAD_OP_IN, 8'h1B, 3'h0, 8'h00, 8'h0F, 1'h0, 1'h0);
        xfer(`IOSAD_OP_SET_BIT, 8'h1B, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_CLR_BIT, 8'h1B, 3'h1, 8'h00, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_STORE, 8'h3B, 3'h0, 8'h04, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_LOAD, 8'h3B, 3'h0, 8'h00, 8'h0A, 1'h0, 1'h0);
        // Clear bits 1 and 3 while bit 1 is set again on the clearing edge
        fork
            xfer(`IOSAD_OP_STORE, 8'h3B, 3'h0, 8'h0A, 8'h00, 1'h0, 1'h0);
            begin
                repeat (2) @(posedge clk);
                flag_event <= 8'h02;
                @(posedge clk);
                flag_event <= 8'h00;
            end
        join
        xfer(`IOSAD_OP_LOAD, 8'h3B, 3'h0, 8'h00, 8'h02, 1'h0, 1'h0);
        $display("test flags done");
    endtask

    // Reserved places are only read, never written
    task t_unmap;
        xfer(`IOSAD_OP_LOAD, 8'h50, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_IN, 8'h30, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        xfer(`IOSAD_OP_LOAD, 8'h10, 3'h0, 8'h00, 8'h00, 1'h0, 1'h1);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        xfer(`IOSAD_OP_IN, 8'h1C, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        $display("test unmap done");
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_store;
        t_periph;
        t_bits;
        t_flags;
        t_unmap;
        close_out;
    end
endmodule // io_space_access_decoder_tb
